// File: rtl/omh_overlay.sv
// Mesh, halftone and second colour position logic of an OSD generator.
// Assumes OSD pixel inputs on hclk, one hclk per half dot period, sync pins asynchronous.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module omh_overlay #(
	parameter int ADDR_W    = 8,
	parameter int HALF_DOTS = 1
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	// Sync pins
	input  wire logic              hsync_pin,
	input  wire logic              vsync_pin,
	// OSD pixel stream
	input  wire logic              interlaced,
	input  wire logic              row_start,
	input  wire logic [4:0]        char_col,
	input  wire logic              right_half,
	input  wire logic              pix_odd,
	input  wire logic              osd_on,
	input  wire logic              osd_fg,
	input  wire logic [2:0]        osd_rgb,
	input  wire logic              osd_blank,
	input  wire logic [1:0]        row_space_ht_dly,
	// Sync interrupt requests
	input  wire logic              hs_irq_req,
	input  wire logic              vs_irq_req,
	input  wire logic              hs_in_service,
	input  wire logic              vs_in_service,
	output logic                   hs_irq_pend,
	output logic                   vs_irq_pend,
	// Shared port pin
	input  wire logic              port_out,
	input  wire logic              port_oe,
	output logic                   halftone_output_pin_o,
	output logic                   halftone_output_pin_oe,
	// Video mixing outputs
	output logic [2:0]             rgb_out,
	output logic                   blank_out,
	output logic                   second_color_sel
);

	localparam int BLEN = omh_pkg::BLANK_STEPS_MAX * HALF_DOTS;
	localparam int HLEN = omh_pkg::HT_STEPS_MAX * HALF_DOTS;

	typedef struct packed {
		logic [4:0]      col_start;
		logic [4:0]      col_end;
		logic [7:0]      row_en;
		logic [7:0]      mesh_ctl;
		logic [6:0]      sc_pos;
		logic            hs_s1;
		logic            hs_s2;
		logic            vs_s1;
		logic            vs_s2;
		logic            vs_prev;
		logic            field_hw;
		logic            row_mesh;
		logic            field_used;
		logic            hs_pend;
		logic            vs_pend;
		logic            ap_valid;
		logic            ap_write;
		logic [5:0]      ap_idx;
		logic [31:0]     rdata;
		logic            ready;
		logic            resp;
		logic [BLEN-1:0] blank_pipe;
		logic [HLEN-1:0] ht_pipe;
		logic [2:0]      rgb;
		logic            blank;
		logic            pin;
		logic            pin_oe;
		logic            sc_sel;
	} omh_state_type;

	omh_state_type s_reg;
	omh_state_type s_next;

	logic       in_window;
	logic       show_phase;
	logic       ht_mode;
	logic       ht_active;
	logic       blank_pre;
	logic       ht_pre;
	logic [2:0] rgb_pre;
	logic [2:0] mesh_rgb;
	logic [2:0] ht_code;
	logic [6:0] sc_index;
	logic       vs_rise;
	logic       ap_take;
	logic [5:0] take_idx;

	////////////////////////////////////////////////////////////////////////////////
	// Register read mux
	function automatic logic [31:0] read_mux(input omh_state_type s, input logic [5:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			omh_pkg::IDX_COL_START: v = {omh_pkg::COL_RSV_READ, s.col_start};
			omh_pkg::IDX_COL_END:   v = {omh_pkg::COL_RSV_READ, s.col_end};
			omh_pkg::IDX_ROW_EN:    v = s.row_en;
			omh_pkg::IDX_MESH_CTL:  v = s.mesh_ctl;
			omh_pkg::IDX_SC_POS:    v = {omh_pkg::SC_RSV_READ, s.sc_pos};
			omh_pkg::IDX_STATUS:    v = {4'h0, s.row_mesh, s.field_hw, s.vs_pend, s.hs_pend};
			default:                v = 8'h00;
		endcase
		return {24'h000000, v};
	endfunction : read_mux

	////////////////////////////////////////////////////////////////////////////////
	// Pixel path
	always_comb begin
		ht_mode  = s_reg.mesh_ctl[omh_pkg::HT_PIN_BIT];
		mesh_rgb = {s_reg.mesh_ctl[omh_pkg::MESH_RED_BIT],
			s_reg.mesh_ctl[omh_pkg::MESH_GREEN_BIT],
			s_reg.mesh_ctl[omh_pkg::MESH_BLUE_BIT]};
		in_window = s_reg.row_mesh && s_reg.mesh_ctl[omh_pkg::MESH_EN_BIT] && interlaced && osd_on
			&& (char_col >= s_reg.col_start)
			&& (char_col < s_reg.col_end);
		show_phase = (pix_odd ^ s_reg.field_used) == 1'b0;
		ht_active  = ht_mode && in_window && (s_reg.row_en[omh_pkg::HT_FG_BIT] || !osd_fg);
		ht_pre     = ht_active ^ s_reg.mesh_ctl[omh_pkg::FIELD_POL_BIT];
		rgb_pre    = osd_rgb;
		blank_pre  = osd_blank;
		if (ht_active && !osd_fg) begin
			rgb_pre   = 3'h0;
			blank_pre = 1'b0;
		end else if (!ht_mode && in_window && !osd_fg) begin
			rgb_pre   = show_phase ? mesh_rgb : 3'h0;
			blank_pre = show_phase;
		end
		ht_code  = {row_space_ht_dly, s_reg.mesh_ctl[omh_pkg::HT_DLY_LO_BIT]};
		sc_index = {1'b0, char_col, right_half} + omh_pkg::SC_OFFSET;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		int unsigned b_tap;
		int unsigned h_tap;
		b_tap  = 0;
		h_tap  = 0;
		s_next = s_reg;

		s_next.hs_s1   = hsync_pin;
		s_next.hs_s2   = s_reg.hs_s1;
		s_next.vs_s1   = vsync_pin;
		s_next.vs_s2   = s_reg.vs_s1;
		s_next.vs_prev = s_reg.vs_s2;
		vs_rise        = s_reg.vs_s2 && !s_reg.vs_prev;
		if (vs_rise) begin
			s_next.field_hw = s_reg.hs_s2;
		end

		if (vs_rise) begin
			s_next.row_mesh = 1'b0;
		end else if (row_start) begin
			s_next.row_mesh = s_reg.row_en[omh_pkg::ROW_MESH_BIT];
		end
		if (!s_reg.row_mesh) begin
			s_next.field_used = s_reg.mesh_ctl[omh_pkg::SW_MESH_BIT]
				? s_reg.mesh_ctl[omh_pkg::FIELD_POL_BIT] : s_reg.field_hw;
		end

		// Data phase write, low byte lane
		if (s_reg.ap_valid && s_reg.ap_write) begin
			case (s_reg.ap_idx)
				omh_pkg::IDX_COL_START: s_next.col_start = hwdata[4:0];
				omh_pkg::IDX_COL_END:   s_next.col_end   = hwdata[4:0];
				omh_pkg::IDX_ROW_EN:    s_next.row_en    = hwdata[7:0];
				omh_pkg::IDX_MESH_CTL:  s_next.mesh_ctl  = hwdata[7:0];
				omh_pkg::IDX_SC_POS:    s_next.sc_pos    = hwdata[6:0];
				omh_pkg::IDX_STATUS: begin
					if (hwdata[omh_pkg::ST_HS_PEND_BIT]) begin
						s_next.hs_pend = 1'b0;
					end
					if (hwdata[omh_pkg::ST_VS_PEND_BIT]) begin
						s_next.vs_pend = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Pending set wins over clear
		if (hs_irq_req && (s_reg.sc_pos[omh_pkg::IRQ_OPT_BIT] || !vs_in_service)) begin
			s_next.hs_pend = 1'b1;
		end
		if (vs_irq_req && (s_reg.sc_pos[omh_pkg::IRQ_OPT_BIT] || !hs_in_service)) begin
			s_next.vs_pend = 1'b1;
		end

		// Address phase
		ap_take         = hsel && htrans[1] && hready;
		take_idx        = haddr[7:2];
		s_next.ap_valid = ap_take;
		s_next.ap_write = ap_take && hwrite;
		s_next.ap_idx   = take_idx;
		s_next.ready    = 1'b1;
		s_next.resp     = 1'b0;
		if (ap_take && !hwrite) begin
			s_next.rdata = read_mux(s_next, take_idx);
		end

		// Half dot delay lines
		s_next.blank_pipe = {s_reg.blank_pipe[BLEN-2:0], blank_pre};
		s_next.ht_pipe    = {s_reg.ht_pipe[HLEN-2:0], ht_pre};
		b_tap = int'(s_reg.row_en[7:omh_pkg::BLANK_DLY_LSB]) * HALF_DOTS;
		h_tap = int'(ht_code) * HALF_DOTS;
		s_next.blank = (b_tap == 0) ? blank_pre : s_reg.blank_pipe[b_tap-1];
		s_next.rgb   = rgb_pre;
		s_next.sc_sel = osd_on && (sc_index >= s_reg.sc_pos[5:0]);
		if (ht_mode) begin
			s_next.pin    = (h_tap == 0) ? ht_pre : s_reg.ht_pipe[h_tap-1];
			s_next.pin_oe = 1'b1;
		end else begin
			s_next.pin    = port_out;
			s_next.pin_oe = port_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg           <= '0;
			s_reg.col_start <= omh_pkg::COLUMN_RESET;
			s_reg.col_end   <= omh_pkg::COLUMN_RESET;
			s_reg.row_en    <= omh_pkg::ROW_EN_RESET;
			s_reg.mesh_ctl  <= omh_pkg::MESH_CTL_RESET;
			s_reg.sc_pos    <= omh_pkg::SC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout              = s_reg.ready;
	assign hrdata                 = s_reg.rdata;
	assign hresp                  = s_reg.resp;
	assign hs_irq_pend            = s_reg.hs_pend;
	assign vs_irq_pend            = s_reg.vs_pend;
	assign halftone_output_pin_o  = s_reg.pin;
	assign halftone_output_pin_oe = s_reg.pin_oe;
	assign rgb_out                = s_reg.rgb;
	assign blank_out              = s_reg.blank;
	assign second_color_sel       = s_reg.sc_sel;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	blank_delay_two_a: assert property (
		(s_reg.row_en[7:4] == 4'h2) && ($past(s_reg.row_en[7:4], 1) == 4'h2) |=>
		blank_out == $past(blank_pre, 3))
		else $error("blank delay of one dot period wrong");

	blank_no_delay_a: assert property (
		s_reg.row_en[7:4] == 4'h0 |=> blank_out == $past(blank_pre))
		else $error("blank not passed through at code zero");

	halftone_delay_a: assert property (
		ht_mode && (ht_code == 3'h3) && ($past(ht_code, 1) == 3'h3) && $past(ht_mode, 2) |=>
		halftone_output_pin_o == $past(ht_pre, 4))
		else $error("halftone delay wrong");

	pin_normal_io_a: assert property (
		!ht_mode |=> (halftone_output_pin_o == $past(port_out)) && (halftone_output_pin_oe == $past(port_oe)))
		else $error("pin not released to port logic");

	pin_halftone_drive_a: assert property (
		ht_mode |=> halftone_output_pin_oe)
		else $error("pin not driven in halftone mode");

	pend_blocked_a: assert property (
		!s_reg.sc_pos[6] && vs_in_service && hs_irq_req && !s_reg.hs_pend |=> !s_reg.hs_pend)
		else $error("hsync held pending with option clear");

	pend_held_a: assert property (
		s_reg.sc_pos[6] && hs_irq_req |=> s_reg.hs_pend)
		else $error("hsync not pending with option set");

	next_row_mesh_a: assert property (
		row_start && !vs_rise |=> s_reg.row_mesh == $past(s_reg.row_en[0]))
		else $error("row mesh not taken at row start");

	field_hold_a: assert property (
		s_reg.row_mesh ##1 s_reg.row_mesh |-> $stable(s_reg.field_used))
		else $error("field changed inside mesh window");

	sw_field_a: assert property (
		!s_reg.row_mesh && s_reg.mesh_ctl[1] |=> s_reg.field_used == $past(s_reg.mesh_ctl[2]))
		else $error("software field not used");

	mesh_colour_a: assert property (
		!ht_mode && in_window && !osd_fg && show_phase |=>
		(rgb_out == {$past(s_reg.mesh_ctl[4]), $past(s_reg.mesh_ctl[5]), $past(s_reg.mesh_ctl[6])}) && blank_out)
		else $error("mesh colour wrong");

	second_pos_a: assert property (
		osd_on && (char_col == 5'h00) && !right_half && (s_reg.sc_pos[5:0] == 6'h03) |=> second_color_sel)
		else $error("second colour offset wrong");

	hs_pend_set_a: assert property (
		hs_irq_req && (s_reg.sc_pos[omh_pkg::IRQ_OPT_BIT] || !vs_in_service) |=>
		s_reg.hs_pend)
		else $error("hsync request not held pending");

	vs_pend_set_a: assert property (
		vs_irq_req && (s_reg.sc_pos[omh_pkg::IRQ_OPT_BIT] || !hs_in_service) |=>
		s_reg.vs_pend)
		else $error("vsync request not held pending");

	status_clear_a: assert property (
		s_reg.ap_valid && s_reg.ap_write && (s_reg.ap_idx == omh_pkg::IDX_STATUS) && hwdata[0] && !hs_irq_req |=>
		!s_reg.hs_pend)
		else $error("hsync pending not cleared");

	progressive_pass_a: assert property (
		!interlaced |=> rgb_out == $past(osd_rgb))
		else $error("overlay altered in progressive video");

	outside_window_a: assert property (
		(char_col < s_reg.col_start) || (char_col >= s_reg.col_end) |=> rgb_out == $past(osd_rgb))
		else $error("overlay altered outside mesh window");

	mesh_clear_phase_a: assert property (
		!ht_mode && in_window && !osd_fg && !show_phase |=> rgb_out == 3'h0)
		else $error("mesh transparent pixel coloured");

	fg_excluded_a: assert property (
		ht_mode && osd_fg && !s_reg.row_en[omh_pkg::HT_FG_BIT] && (ht_code == 3'h0) |=>
		halftone_output_pin_o == $past(s_reg.mesh_ctl[omh_pkg::FIELD_POL_BIT]))
		else $error("foreground pixel halftoned");

	halftone_no_delay_a: assert property (
		ht_mode && (ht_code == 3'h0) |=> halftone_output_pin_o == $past(ht_pre))
		else $error("halftone not passed through at code zero");

	field_hw_a: assert property (
		vs_rise |=> s_reg.field_hw == $past(s_reg.hs_s2))
		else $error("hardware field not taken at vsync");

	mesh_seen_c: cover property (!ht_mode && in_window && show_phase ##1 !show_phase);
	halftone_seen_c: cover property (ht_active ##[1:8] halftone_output_pin_o != $past(halftone_output_pin_o));
	pend_clear_c: cover property (s_reg.hs_pend ##1 !s_reg.hs_pend);
	field_flip_c: cover property (vs_rise && (s_reg.hs_s2 != s_reg.field_hw));
	second_half_c: cover property (osd_on && right_half ##1 second_color_sel);

endmodule : omh_overlay

`default_nettype wire

// File: rtl/omh_pkg.sv
// Constants for the mesh and halftone overlay block.
// Assumes a 32-bit AHB-Lite register bus and a dot rate at half the bus clock.
package omh_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_COL_START  = 6'h04;
	localparam logic [5:0] IDX_COL_END    = 6'h05;
	localparam logic [5:0] IDX_ROW_EN     = 6'h06;
	localparam logic [5:0] IDX_MESH_CTL   = 6'h07;
	localparam logic [5:0] IDX_SC_POS     = 6'h08;
	localparam logic [5:0] IDX_STATUS     = 6'h09;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BLANK_DLY_LSB  = 4;
	localparam int HT_FG_BIT      = 3;
	localparam int ROW_MESH_BIT   = 0;
	localparam int HT_DLY_LO_BIT  = 7;
	localparam int MESH_BLUE_BIT  = 6;
	localparam int MESH_GREEN_BIT = 5;
	localparam int MESH_RED_BIT   = 4;
	localparam int HT_PIN_BIT     = 3;
	localparam int FIELD_POL_BIT  = 2;
	localparam int SW_MESH_BIT    = 1;
	localparam int MESH_EN_BIT    = 0;
	localparam int IRQ_OPT_BIT    = 6;
	localparam int ST_HS_PEND_BIT = 0;
	localparam int ST_VS_PEND_BIT = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Reset and read-back values
	localparam logic [7:0] ROW_EN_RESET   = 8'h00;
	localparam logic [7:0] MESH_CTL_RESET = 8'h00;
	localparam logic [4:0] COLUMN_RESET   = 5'h00;
	localparam logic [6:0] SC_RESET       = 7'h00;
	localparam logic [2:0] COL_RSV_READ   = 3'h7;
	localparam logic       SC_RSV_READ    = 1'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Second colour screen offset in half columns
	localparam logic [6:0] SC_OFFSET      = 7'h03;

	////////////////////////////////////////////////////////////////////////////////
	// Delay codes: largest step counts in half dot periods
	localparam int BLANK_STEPS_MAX = 15;
	localparam int HT_STEPS_MAX    = 7;

endpackage : omh_pkg

// File: verification/omh_mixer_model.sv
// Model of the video mixing circuit beside the overlay.
// Assumes overlay outputs change on hclk; the shared pin has no pull resistor.
`timescale 1ns/1ps
`default_nettype none
module omh_mixer_model (
	// Clock
	input  wire logic       hclk,
	// Overlay outputs
	input  wire logic [2:0] rgb,
	input  wire logic       blank,
	input  wire logic       pin_o,
	input  wire logic       pin_oe,
	// Mixed result
	output logic            pin_lvl,
	output logic [3:0]      video
);
	logic last;
	initial last = 1'b0;
	always @(posedge hclk) begin
		if (pin_oe)
			last <= pin_o;
	end
	// Released pin shows the inverse of the last driven level
	assign pin_lvl = pin_oe ? pin_o : ~last;
	// Blank picks OSD colour, halftone darkens the picture
	assign video = blank ? {1'b1, rgb} : (pin_lvl ? 4'h1 : 4'h7);
endmodule : omh_mixer_model
`default_nettype wire

// File: verification/omh_overlay_test.sv
// Self-checking bench for the mesh and halftone overlay.
// Assumes omh_pkg, omh_overlay and omh_mixer_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module omh_overlay_test;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, interlaced, row_start, right_half;
	logic        pix_odd, osd_on, osd_fg, osd_blank, hsync_pin, vsync_pin, hs_irq_req, vs_irq_req;
	logic        hs_in_service, vs_in_service, hs_irq_pend, vs_irq_pend, port_out, port_oe;
	logic        pin_o, pin_oe, blank_out, second_color_sel, pin_lvl;
	logic [1:0]  htrans, row_space_ht_dly;
	logic [2:0]  hsize, osd_rgb, rgb_out;
	logic [3:0]  video;
	logic [4:0]  char_col;
	logic [7:0]  haddr, r;
	logic [31:0] hwdata, hrdata, rd, seed;
	int          errors, n_checks, c, p;

	omh_overlay i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .hsync_pin, .vsync_pin, .interlaced, .row_start, .char_col, .right_half, .pix_odd,
		.osd_on, .osd_fg, .osd_rgb, .osd_blank, .row_space_ht_dly, .hs_irq_req, .vs_irq_req, .hs_in_service,
		.vs_in_service, .hs_irq_pend, .vs_irq_pend, .port_out, .port_oe, .halftone_output_pin_o(pin_o),
		.halftone_output_pin_oe(pin_oe), .rgb_out, .blank_out, .second_color_sel
	);
	omh_mixer_model i_mix (.hclk, .rgb(rgb_out), .blank(blank_out), .pin_o, .pin_oe, .pin_lvl, .video);

	initial hclk = 1'b0;
	always #2.5 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h00: return 8'h00;
			8'h10, 8'h14: return {3'h7, d[4:0]};
			8'h20: return {1'b1, d[6:0]};
			default: return d;
		endcase
	endfunction : rb
	task automatic end_sim();
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic waitr();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 64);
		if (hreadyout !== 1'b1) begin
			errors++;
			end_sim();
		end
	endtask : waitr
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		waitr();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		waitr();
		rd = hrdata;
	endtask : bus
	// Vsync ends the mesh row, control is written, then one OSD row begins
	task automatic setc(input logic [7:0] ctl, input logic hs);
		@(posedge hclk);
		hsync_pin <= hs;
		repeat (2) @(posedge hclk);
		vsync_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		vsync_pin <= 1'b0;
		bus(1'b1, 8'h1c, ctl);
		repeat (2) @(posedge hclk);
		row_start <= 1'b1;
		@(posedge hclk);
		row_start <= 1'b0;
	endtask : setc
	task automatic look(input logic [4:0] cc, input logic h, input logic o, input logic f);
		@(posedge hclk);
		char_col <= cc;
		right_half <= h;
		pix_odd <= o;
		osd_fg <= f;
		repeat (20) @(posedge hclk);
		#1;
	endtask : look
	// One-cycle pulse in, count cycles until it shows
	task automatic scan(input int e, input logic ht);
		int n;
		n = 0;
		@(posedge hclk);
		char_col <= 5'h1f;
		osd_blank <= 1'b0;
		repeat (20) @(posedge hclk);
		if (ht)
			char_col <= 5'h05;
		else
			osd_blank <= 1'b1;
		do begin
			@(posedge hclk);
			char_col <= 5'h1f;
			osd_blank <= 1'b0;
			#1;
			n++;
		end while ((ht ? pin_lvl : blank_out) !== 1'b1 && n < 40);
		chk("delay", e, n);
	endtask : scan

	initial begin
		repeat (100000) @(posedge hclk);
		errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{hsel, hwrite, hresetn, row_start, right_half, pix_odd, osd_fg, hsync_pin, vsync_pin} = '0;
		{hs_irq_req, vs_irq_req, hs_in_service, vs_in_service, port_out, port_oe, row_space_ht_dly} = '0;
		{htrans, haddr, hwdata, char_col} = '0;
		{interlaced, osd_on, osd_blank} = 3'h7;
		{hsize, osd_rgb} = 6'h15;
		{errors, n_checks} = '0;
		seed = 32'hdcc99795;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// Reset values, then random write and read back
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, (i == 0) ? 8'h00 : 8'h0c + 8'(4 * i), 8'h00);
			chk("reset value", rb((i == 0) ? 8'h00 : 8'h0c + 8'(4 * i), 8'h00), rd);
		end
		chk("response", 0, hresp);
		for (int k = 0; k < 18; k++) begin
			r = rnd();
			bus(1'b1, (k % 6 == 0) ? 8'h00 : 8'h0c + 8'(4 * (k % 6)), r);
			bus(1'b0, (k % 6 == 0) ? 8'h00 : 8'h0c + 8'(4 * (k % 6)), 8'h00);
			chk("read back", rb((k % 6 == 0) ? 8'h00 : 8'h0c + 8'(4 * (k % 6)), r), rd);
		end
		// Second colour position
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			c = (i < 2) ? 0 : rnd() % 24;
			p = (i == 0) ? 3 : (i == 1) ? 4 : r[5:0];
			bus(1'b1, 8'h20, {2'b00, p[5:0]});
			look(c[4:0], (i < 2) ? 1'b0 : r[6], 1'b0, 1'b0);
			chk("second colour", (2 * c + ((i < 2) ? 0 : r[6]) + 3) >= p, second_color_sel);
		end
		// Sync interrupt pending option
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h20, {1'b0, i[0], 6'h00});
			hs_in_service <= !i[1];
			vs_in_service <= i[1];
			@(posedge hclk);
			hs_irq_req <= 1'b1;
			vs_irq_req <= 1'b1;
			@(posedge hclk);
			hs_irq_req <= 1'b0;
			vs_irq_req <= 1'b0;
			repeat (3) @(posedge hclk);
			chk("hs pending", i[0] || !i[1], hs_irq_pend);
			chk("vs pending", i[0] || i[1], vs_irq_pend);
			bus(1'b0, 8'h24, 8'h00);
			chk("status", {i[0] || i[1], i[0] || !i[1]}, rd[1:0]);
			bus(1'b1, 8'h24, 8'h03);
			#1;
			chk("cleared", 0, {hs_irq_pend, vs_irq_pend});
		end
		// Mesh window, colour and software field
		bus(1'b1, 8'h10, 8'h02);
		bus(1'b1, 8'h14, 8'h0a);
		bus(1'b1, 8'h18, 8'h01);
		for (int k = 0; k < 8; k++) begin
			setc({1'b0, k[2:0], 1'b0, k[0], 2'b11}, 1'b0);
			for (int o = 0; o < 2; o++) begin
				look(5'h05, 1'b0, o[0], 1'b0);
				chk("mesh blank", (o[0] ^ k[0]) == 1'b0, blank_out);
				if ((o[0] ^ k[0]) == 1'b0)
					chk("mesh colour", {k[0], k[1], k[2]}, rgb_out);
			end
		end
		bus(1'b1, 8'h1c, 8'h73);
		look(5'h05, 1'b0, 1'b1, 1'b0);
		chk("field held", 1, blank_out);
		for (int h = 0; h < 2; h++) begin
			setc(8'h71, h[0]);
			for (int o = 0; o < 2; o++) begin
				look(5'h05, 1'b0, o[0], 1'b0);
				chk("hw field", o == h, blank_out);
			end
			bus(1'b0, 8'h24, 8'h00);
			chk("field status", h, rd[2]);
		end
		for (int i = 0; i < 4; i++) begin
			c = (i < 2) ? i + 1 : i + 7;
			look(c[4:0], 1'b0, 1'b0, 1'b0);
			chk("window", !(c >= 2 && c < 10), blank_out);
		end
		@(posedge hclk);
		interlaced <= 1'b0;
		look(5'h05, 1'b0, 1'b0, 1'b0);
		chk("progressive", 4'hd, {blank_out, rgb_out});
		@(posedge hclk);
		interlaced <= 1'b1;
		bus(1'b1, 8'h18, 8'h00);
		setc(8'h71, 1'b1);
		look(5'h05, 1'b0, 1'b0, 1'b0);
		chk("row off", 4'hd, {blank_out, rgb_out});
		// Halftone on the shared pin
		bus(1'b1, 8'h18, 8'h01);
		for (int i = 0; i < 4; i++) begin
			if (i == 2)
				bus(1'b1, 8'h18, 8'h09);
			setc((i == 3) ? 8'h0d : 8'h09, 1'b0);
			look(5'h05, 1'b0, 1'b0, i == 1 || i == 2);
			chk("halftone pin", {1'b1, i != 1 && i != 3}, {pin_oe, pin_lvl});
			chk("halftone blank", i == 1 || i == 2, blank_out);
			if (i == 0)
				chk("halftone video", 4'h1, video);
		end
		setc(8'h01, 1'b0);
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			@(posedge hclk);
			port_out <= r[0];
			port_oe <= r[1];
			repeat (3) @(posedge hclk);
			#1;
			chk("normal pin", r[1:0], {pin_oe, pin_o});
		end
		// Half dot delay codes
		bus(1'b1, 8'h18, 8'h01);
		setc(8'h00, 1'b0);
		for (int k = 0; k < 16; k++) begin
			bus(1'b1, 8'h18, {k[3:0], 4'h1});
			scan(k + 1, 1'b0);
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge hclk);
			row_space_ht_dly <= k[2:1];
			setc({k[0], 7'h09}, 1'b0);
			scan(k + 1, 1'b1);
		end
		end_sim();
	end
endmodule : omh_overlay_test
`default_nettype wire
